/* File: ecr_pkg.sv */
/*
 Shared constants and carrier types of the Ethernet status and
 collision/retry block: register map, field layout, reset values.
 Assumes an APB4 master with 32-bit data and byte strobes.
*/
package ecr_pkg;

   localparam int          ECR_AW          = 8;
   // Register word offsets; ctrl, clrt and mask bases have clr/set/invert aliases at +4/+8/+c
   localparam logic [7:0]  ECR_CTRL_OFS    = 8'h00;
   localparam logic [7:0]  ECR_STAT_OFS    = 8'h10;
   localparam logic [7:0]  ECR_CLRT_OFS    = 8'h20;
   localparam logic [7:0]  ECR_IRQ_OFS     = 8'h30;
   localparam logic [7:0]  ECR_MASK_OFS    = 8'h40;
   localparam logic [1:0]  ECR_OP_NORM     = 2'h0;
   localparam logic [1:0]  ECR_OP_CLR      = 2'h1;
   localparam logic [1:0]  ECR_OP_SET      = 2'h2;
   localparam logic [1:0]  ECR_OP_INV      = 2'h3;

   // Control register
   localparam int          ECR_ON_BIT      = 15;
   localparam logic [31:0] ECR_CTRL_MASK   = 32'h0000_8000;
   localparam logic [31:0] ECR_CTRL_RST    = 32'h0000_0000;

   // Status register
   localparam int          ECR_CBUSY_BIT   = 7;
   localparam int          ECR_TBUSY_BIT   = 6;

   // Collision window / retry limit register
   localparam int          ECR_CWIN_LSB    = 8;
   localparam int          ECR_CWIN_W      = 6;
   localparam int          ECR_RETRY_LIMIT_LSB    = 0;
   localparam int          ECR_RETRY_LIMIT_W      = 4;
   localparam logic [31:0] ECR_CLRT_MASK   = 32'h0000_3f0f;
   localparam logic [5:0]  ECR_CWIN_RST    = 6'h37;
   localparam logic [3:0]  ECR_RETRY_LIMIT_RST    = 4'hf;

   // Interrupt status and mask layout
   localparam int          ECR_NIRQ        = 4;
   localparam int          ECR_EV_DONE     = 0;
   localparam int          ECR_EV_EXCESS   = 1;
   localparam int          ECR_EV_LATE     = 2;
   localparam int          ECR_EV_IDLE     = 3;
   localparam logic [3:0]  ECR_MASK_RST    = 4'h0;

   // Strobe patterns that count as halfword or word accesses
   localparam logic [3:0]  ECR_STRB_LO     = 4'h3;
   localparam logic [3:0]  ECR_STRB_HI     = 4'hc;
   localparam logic [3:0]  ECR_STRB_WORD   = 4'hf;

   localparam int          ECR_BCNT_W      = 7;

   typedef struct packed {
      logic tx_start;
      logic tx_byte;
      logic tx_done;
      logic tx_reject;
      logic xfer_busy;
   } ecr_mac_ev_t;

   typedef struct packed {
      logic controller_active_flag;
      logic transmit_active_flag;
      logic module_on;
      logic tx_retry;
      logic tx_abort;
   } ecr_mac_ctl_t;

   typedef enum logic [0:0] {
      ECR_TX_IDLE = 1'b0,
      ECR_TX_SEND = 1'b1
   } ecr_tx_state_t;

endpackage

/* File: ecr_top.sv */
/*
 Ethernet controller status and half-duplex collision window / retry
 limit logic behind an APB4 slave, with a read-to-clear interrupt.
 Assumes MAC transmit events arrive as pclk-synchronous pulses and the
 MII collision pin is asynchronous to pclk.
*/
// Decided for this implementation: the register offsets and the APB interface to the registers.
// Function
// RULE_01: Controller-active is 1 while switched on or finishing, 0 only when idle.
// RULE_02: After switch-off, controller-active stays high until the running transfer ends.
// RULE_03: Transmit-active is high while a packet is sent, low when transmit is idle.
// RULE_04: Transmit-active may fall on abort or reject without a completion event.
// RULE_05: Transmit-active is forced low whenever the module-on bit is low.
// RULE_06: Six-bit read/write slot length in bits 13:8, reset value 0x37.
// RULE_07: Window counts from transmit start, preamble included; field is end byte count.
// RULE_08: Four-bit retry limit in bits 3:0; exceeding it aborts the packet.
// RULE_09: Retry limit resets to 0xf, fifteen attempts.
// RULE_10: Halfword and word writes accepted; byte writes silently ignored.
// RULE_11: Same width check applies to the clear, set and invert aliases.
// RULE_12: Bits 31:14 and 7:4 of the collision register read zero, ignore writes.
`timescale 1ns/1ps

module ecr_top
   import ecr_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ECR_AW-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic       [31:0]       prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire ecr_mac_ev_t        mac_ev,
   input  wire logic               mii_col,
   output ecr_mac_ctl_t            mac_ctl,
   output logic                    irq
);

   logic                     setup_ph;
   logic                     acc_ph;
   logic                     addr_ok;
   logic                     width_ok;
   logic [1:0]               op;
   logic [7:0]               base;
   logic [31:0]              lane_mask;
   logic [31:0]              rd_d;
   logic [31:0]              prdata_q;
   logic                     slverr_q;

   logic [31:0]              ctrl_q;
   logic [5:0]               cwin_q;
   logic [3:0]               retry_limit_q;
   logic [ECR_NIRQ-1:0]      irq_stat_q;
   logic [ECR_NIRQ-1:0]      irq_mask_q;
   logic [ECR_NIRQ-1:0]      ev;
   logic                     irq_rd_clr;

   logic [2:0]               col_sync_q;
   logic                     col_q;
   logic                     col_rise;

   ecr_tx_state_t            tx_state_q;
   logic [ECR_BCNT_W-1:0]    bcnt_q;
   logic [3:0]               retry_cnt_q;
   logic                     in_window;
   logic                     tx_retry_q;
   logic                     tx_abort_q;
   logic                     ev_done;
   logic                     ev_excess;
   logic                     ev_late;
   logic                     cact_q;
   logic                     cact_d;
   logic                     module_on;
   logic                     tx_active;

   // APB decode: fixed zero-wait answer, read data staged in setup phase
   assign setup_ph = psel & ~penable;
   assign acc_ph   = psel & penable;
   assign op       = paddr[3:2];
   assign base     = {paddr[7:4], 4'h0};
   assign pready   = 1'b1;
   assign pslverr  = slverr_q;
   assign prdata   = prdata_q;

   always_comb
   begin
      addr_ok = 1'b0;
      case (base)
         ECR_CTRL_OFS: addr_ok = 1'b1;
         ECR_CLRT_OFS: addr_ok = 1'b1;
         ECR_MASK_OFS: addr_ok = 1'b1;
         ECR_STAT_OFS: addr_ok = (op == ECR_OP_NORM);
         ECR_IRQ_OFS:  addr_ok = (op == ECR_OP_NORM);
         default:      addr_ok = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0)
      begin
         addr_ok = 1'b0;
      end
   end

   // Byte writes are dropped without an error; aliases share the check
   always_comb
   begin
      width_ok = 1'b0;
      case (pstrb)
         ECR_STRB_LO:   width_ok = 1'b1; // see RULE_10
         ECR_STRB_HI:   width_ok = 1'b1; // see RULE_10
         ECR_STRB_WORD: width_ok = 1'b1; // see RULE_10
         default:       width_ok = 1'b0; // see RULE_11
      endcase
   end

   assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   function automatic logic [31:0] apply_op
   (
      input logic [31:0] cur,
      input logic [31:0] wd,
      input logic [31:0] lanes,
      input logic [1:0]  kind
   );
      logic [31:0] res;
      res = cur;
      case (kind)
         ECR_OP_NORM: res = (cur & ~lanes) | (wd & lanes);
         ECR_OP_CLR:  res = cur & ~(wd & lanes);
         ECR_OP_SET:  res = cur | (wd & lanes);
         ECR_OP_INV:  res = cur ^ (wd & lanes);
         default:     res = cur;
      endcase
      return res;
   endfunction

   logic                     wr_ok;
   logic [31:0]              clrt_cur;
   logic [31:0]              clrt_new;
   logic [31:0]              ctrl_new;
   logic [31:0]              mask_new;

   assign wr_ok    = acc_ph & pwrite & addr_ok & width_ok; // see RULE_10
   assign clrt_cur = {18'h0, cwin_q, 4'h0, retry_limit_q};
   assign clrt_new = apply_op(clrt_cur, pwdata, lane_mask, op) & ECR_CLRT_MASK; // see RULE_12
   assign ctrl_new = apply_op(ctrl_q, pwdata, lane_mask, op) & ECR_CTRL_MASK;
   assign mask_new = apply_op({28'h0, irq_mask_q}, pwdata, lane_mask, op);

   always_comb
   begin
      rd_d = 32'h0;
      case (base)
         ECR_CTRL_OFS: rd_d = ctrl_q;
         ECR_CLRT_OFS: rd_d = clrt_cur; // see RULE_12
         ECR_MASK_OFS: rd_d = {28'h0, irq_mask_q};
         ECR_IRQ_OFS:  rd_d = {28'h0, irq_stat_q};
         ECR_STAT_OFS:
         begin
            rd_d[ECR_CBUSY_BIT] = cact_q;
            rd_d[ECR_TBUSY_BIT] = tx_active;
         end
         default:      rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0;
         slverr_q <= 1'b0;
      end
      else if (setup_ph)
      begin
         prdata_q <= pwrite ? 32'h0 : rd_d;
         slverr_q <= ~addr_ok;
      end
   end

   // Control register: module-on bit only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= ECR_CTRL_RST;
      end
      else if (wr_ok && base == ECR_CTRL_OFS)
      begin
         ctrl_q <= ctrl_new;
      end
   end

   assign module_on = ctrl_q[ECR_ON_BIT];

   // Collision window and retry limit fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cwin_q <= ECR_CWIN_RST; // see RULE_06
         retry_limit_q <= ECR_RETRY_LIMIT_RST; // see RULE_09
      end
      else if (wr_ok && base == ECR_CLRT_OFS)
      begin
         cwin_q <= clrt_new[ECR_CWIN_LSB +: ECR_CWIN_W]; // see RULE_06
         retry_limit_q <= clrt_new[ECR_RETRY_LIMIT_LSB +: ECR_RETRY_LIMIT_W]; // see RULE_08
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_mask_q <= ECR_MASK_RST;
      end
      else if (wr_ok && base == ECR_MASK_OFS)
      begin
         irq_mask_q <= mask_new[ECR_NIRQ-1:0];
      end
   end

   // Collision pin: three stages, level accepted once stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         col_sync_q <= 3'h0;
         col_q      <= 1'b0;
      end
      else
      begin
         col_sync_q <= {col_sync_q[1:0], mii_col};
         if (col_sync_q[1] == col_sync_q[2])
         begin
            col_q <= col_sync_q[2];
         end
      end
   end

   assign col_rise = (col_sync_q[1] == col_sync_q[2]) & col_sync_q[2] & ~col_q;

   // Byte count runs from the first preamble byte, so it compares straight
   // against the slot length field
   assign in_window = (bcnt_q <= {1'b0, cwin_q}); // see RULE_07

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_state_q <= ECR_TX_IDLE;
      end
      else
      begin
         case (tx_state_q)
            ECR_TX_IDLE:
            begin
               if (module_on && mac_ev.tx_start)
               begin
                  tx_state_q <= ECR_TX_SEND; // see RULE_03
               end
            end
            ECR_TX_SEND:
            begin
               if (!module_on)
               begin
                  tx_state_q <= ECR_TX_IDLE; // see RULE_05
               end
               else if (mac_ev.tx_done || mac_ev.tx_reject)
               begin
                  tx_state_q <= ECR_TX_IDLE; // see RULE_04
               end
               else if (col_rise && (!in_window || retry_cnt_q == retry_limit_q))
               begin
                  tx_state_q <= ECR_TX_IDLE; // see RULE_04
               end
            end
            default:
            begin
               tx_state_q <= ECR_TX_IDLE;
            end
         endcase
      end
   end

   wire tx_send = (tx_state_q == ECR_TX_SEND);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bcnt_q <= '0;
      end
      else if (!tx_send || (col_rise && in_window))
      begin
         bcnt_q <= '0; // see RULE_07
      end
      else if (mac_ev.tx_byte && bcnt_q != '1)
      begin
         bcnt_q <= bcnt_q + 1'b1; // see RULE_07
      end
   end

   // Retransmissions so far; abort once the limit has been used up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         retry_cnt_q <= 4'h0;
      end
      else if (!tx_send)
      begin
         retry_cnt_q <= 4'h0;
      end
      else if (col_rise && in_window && retry_cnt_q != retry_limit_q)
      begin
         retry_cnt_q <= retry_cnt_q + 4'h1; // see RULE_08
      end
   end

   assign ev_done   = tx_send & module_on & mac_ev.tx_done;
   assign ev_excess = tx_send & module_on & ~mac_ev.tx_done & ~mac_ev.tx_reject
                      & col_rise & in_window & (retry_cnt_q == retry_limit_q); // see RULE_08
   assign ev_late   = tx_send & module_on & ~mac_ev.tx_done & ~mac_ev.tx_reject
                      & col_rise & ~in_window;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_retry_q <= 1'b0;
         tx_abort_q <= 1'b0;
      end
      else
      begin
         tx_retry_q <= tx_send & module_on & ~mac_ev.tx_done & ~mac_ev.tx_reject
                       & col_rise & in_window & (retry_cnt_q != retry_limit_q);
         tx_abort_q <= ev_excess | ev_late; // see RULE_08
      end
   end

   // Off forces transmit-active low at once, without waiting for the FSM
   assign tx_active = tx_send & module_on; // see RULE_05

   // Controller stays active after switch-off until transfers drain
   assign cact_d = module_on | tx_active | mac_ev.xfer_busy; // see RULE_01

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cact_q <= 1'b0;
      end
      else
      begin
         cact_q <= cact_d; // see RULE_02
      end
   end

   // Sticky events; a new event wins over the read that clears
   assign ev[ECR_EV_DONE]   = ev_done;
   assign ev[ECR_EV_EXCESS] = ev_excess;
   assign ev[ECR_EV_LATE]   = ev_late;
   assign ev[ECR_EV_IDLE]   = cact_q & ~cact_d;
   assign irq_rd_clr        = acc_ph & ~pwrite & (base == ECR_IRQ_OFS) & (op == ECR_OP_NORM);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_q <= '0;
      end
      else
      begin
         irq_stat_q <= (irq_rd_clr ? '0 : irq_stat_q) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(((irq_rd_clr ? '0 : irq_stat_q) | ev) & irq_mask_q);
      end
   end

   always_comb
   begin
      mac_ctl                        = '0;
      mac_ctl.controller_active_flag = cact_q;    // see RULE_01
      mac_ctl.transmit_active_flag   = tx_active; // see RULE_03
      mac_ctl.module_on              = module_on;
      mac_ctl.tx_retry               = tx_retry_q;
      mac_ctl.tx_abort               = tx_abort_q;
   end

endmodule

/* File: ecr_assertions.sv */
/*
 Concurrent checks on the ports of ecr_top.
 Assumes one pclk domain with presetn active low.
*/
`timescale 1ns/1ps
module ecr_assertions
   import ecr_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ECR_AW-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire ecr_mac_ev_t       mac_ev,
   input wire logic              mii_col,
   input wire ecr_mac_ctl_t      mac_ctl,
   input wire logic              irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_off_tx_low: assert property (!mac_ctl.module_on |-> !mac_ctl.transmit_active_flag)
      else $error("transmit active while module off");
   a_on_active: assert property (mac_ctl.module_on |=> mac_ctl.controller_active_flag)
      else $error("controller not active while on");
   a_busy_hold: assert property (mac_ev.xfer_busy |=> mac_ctl.controller_active_flag)
      else $error("controller inactive during transfer");
   a_idle_low: assert property (!mac_ctl.module_on && !mac_ev.xfer_busy
      |=> !mac_ctl.controller_active_flag)
      else $error("controller active while idle");
   a_tx_begin: assert property (mac_ev.tx_start && mac_ctl.module_on
      && !mac_ctl.transmit_active_flag
      |=> mac_ctl.transmit_active_flag || !mac_ctl.module_on)
      else $error("transmit did not start");
   a_tx_end: assert property (mac_ctl.transmit_active_flag
      && (mac_ev.tx_done || mac_ev.tx_reject) |=> !mac_ctl.transmit_active_flag)
      else $error("transmit did not end");
   a_abort_stops: assert property (mac_ctl.tx_abort
      |-> ##[0:1] !mac_ctl.transmit_active_flag)
      else $error("abort left transmit active");
   // A synchroniser sits on the pin, so a few cycles of lag are expected
   a_col_answer: assert property ($rose(mii_col) && mac_ctl.transmit_active_flag
      |-> ##[2:8] (mac_ctl.tx_retry || mac_ctl.tx_abort))
      else $error("collision got no retry or abort");
   a_clrt_rsvd: assert property (psel && penable && !pwrite && paddr == ECR_CLRT_OFS
      |-> (prdata & ~ECR_CLRT_MASK) == 32'h0)
      else $error("unimplemented collision bits read nonzero");

   c_retry: cover property (mac_ctl.tx_retry);
   c_abort: cover property (mac_ctl.tx_abort);
   c_irq: cover property ($rose(irq));
endmodule

bind ecr_top ecr_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .mac_ev(mac_ev),
   .mii_col(mii_col), .mac_ctl(mac_ctl), .irq(irq));

/* File: ecr_mac_model.sv */
/*
 Behavioural MAC/PHY side: event pulses and the collision pin.
 Assumes the caller enters each task right after a rising pclk edge.
*/
`timescale 1ns/1ps
module ecr_mac_model
   import ecr_pkg::*;
(
   input  wire logic   pclk,
   output ecr_mac_ev_t mac_ev,
   output logic        mii_col
);
   initial
   begin
      mac_ev  = '0;
      mii_col = 1'b0;
   end

   // Bit k of the event struct; tx_byte marks bytes from the first preamble byte
   task automatic pulse(input int k);
      mac_ev[k] <= 1'b1;
      @(posedge pclk);
      mac_ev[k] <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic set_busy(input logic v);
      mac_ev.xfer_busy <= v;
      @(posedge pclk);
   endtask

   // Held three cycles: the pin filter drops anything shorter than two
   task automatic collide();
      mii_col <= 1'b1;
      repeat (3) @(posedge pclk);
      mii_col <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
endmodule

/* File: eth_mac_status_collision_retry_tb_top.sv */
/*
 Self-checking bench for ecr_top: registers over APB, status, collisions, interrupt.
 Assumes the MAC model drives the far side; one 100 MHz clock.
*/
`timescale 1ns/1ps
module eth_mac_status_collision_retry_tb_top;
   import ecr_pkg::*;
   logic              pclk, presetn, psel, penable;
   logic              pwrite, pready, pslverr, irq, mii_col, e;
   logic [ECR_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata, r;
   logic [3:0]        pstrb;
   ecr_mac_ev_t       mac_ev;
   ecr_mac_ctl_t      mac_ctl;
   int                error_cnt = 0, n_tests = 0, cyc = 0, n_retry = 0;

   ecr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mac_ev(mac_ev), .mii_col(mii_col),
      .mac_ctl(mac_ctl), .irq(irq));
   ecr_mac_model mac (.pclk(pclk), .mac_ev(mac_ev), .mii_col(mii_col));

   always #5 pclk = ~pclk;

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (mac_ctl.tx_retry === 1'b1)
         n_retry <= n_retry + 1;
      if (cyc == 20000)
      begin
         error_cnt = error_cnt + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Idle edge after each transfer keeps one assignment per signal per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(r, x);
   endtask

   // Looks at irq (t=0) or transmit-active (t=1) mid-cycle, once settled
   task automatic flag(input bit t, input logic x);
      @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, t ? mac_ctl.transmit_active_flag : irq}, {31'h0, x});
      @(posedge pclk);
   endtask

   task automatic t_regs();
      logic [7:0]  a [5] = '{8'h2c, 8'h24, 8'h28, 8'h20, 8'h20};
      logic [31:0] d [5] = '{32'h3f0f, 32'h0f00, 32'h0005, 32'hffff_ffff, 32'h1505};
      logic [3:0]  s [5] = '{4'h3, 4'h3, 4'h3, 4'hc, 4'h3};
      logic [31:0] x [5] = '{32'h2a0a, 32'h200a, 32'h200f, 32'h200f, 32'h1505};
      rd(ECR_CLRT_OFS, 32'h0000_370f);
      apb(1'b1, ECR_CLRT_OFS, 32'hffff_ffff, 4'hf);
      rd(ECR_CLRT_OFS, 32'h0000_3f0f);
      apb(1'b1, ECR_CLRT_OFS, 32'h1505, 4'hf);
      for (int o = 0; o < 4; o++)
         for (int b = 0; b < 4; b++)
         begin
            apb(1'b1, ECR_CLRT_OFS + 8'(4 * o), 32'h3f0f, 4'h1 << b);
            rd(ECR_CLRT_OFS, 32'h1505);
         end
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, a[i], d[i], s[i]);
         rd(ECR_CLRT_OFS, x[i]);
      end
      rd(8'h50, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask

   task automatic t_status();
      rd(ECR_STAT_OFS, 32'h0);
      apb(1'b1, ECR_CTRL_OFS, 32'h8000, 4'hf);
      rd(ECR_STAT_OFS, 32'h80);
      mac.set_busy(1'b1);
      mac.pulse(4);
      rd(ECR_STAT_OFS, 32'hc0);
      apb(1'b1, ECR_CTRL_OFS, 32'h0, 4'hf);
      flag(1'b1, 1'b0);
      rd(ECR_STAT_OFS, 32'h80);
      mac.set_busy(1'b0);
      rd(ECR_STAT_OFS, 32'h0);
   endtask

   task automatic t_done();
      apb(1'b1, ECR_CTRL_OFS, 32'h8000, 4'hf);
      rd(ECR_IRQ_OFS, 32'h8);
      apb(1'b1, ECR_MASK_OFS, 32'h1, 4'hf);
      mac.pulse(4);
      mac.pulse(3);
      mac.pulse(2);
      flag(1'b0, 1'b1);
      rd(ECR_STAT_OFS, 32'h80);
      rd(ECR_IRQ_OFS, 32'h1);
      flag(1'b0, 1'b0);
   endtask

   // Slot 3 bytes, one retry allowed: boundary retry, late abort, excess abort
   task automatic t_col();
      apb(1'b1, ECR_CLRT_OFS, 32'h0301, 4'hf);
      apb(1'b1, ECR_MASK_OFS, 32'h0, 4'hf);
      mac.pulse(4);
      repeat (3) mac.pulse(3);
      mac.collide();
      chk(32'(n_retry), 32'h1);
      repeat (4) mac.pulse(3);
      mac.collide();
      flag(1'b1, 1'b0);
      mac.pulse(4);
      mac.collide();
      mac.collide();
      chk(32'(n_retry), 32'h2);
      flag(1'b1, 1'b0);
      mac.pulse(4);
      mac.pulse(1);
      flag(1'b1, 1'b0);
      flag(1'b0, 1'b0);
      apb(1'b1, ECR_MASK_OFS, 32'h6, 4'hf);
      flag(1'b0, 1'b1);
      rd(ECR_IRQ_OFS, 32'h6);
      flag(1'b0, 1'b0);
   endtask

   initial
   begin
      pclk = 1'b0;
      presetn <= 1'b0;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= '0;
      pwdata  <= '0;
      pstrb   <= '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_status();
      t_done();
      t_col();
      wrap_up();
   end
endmodule
